// >>> hw/atl_pkg.sv
package atl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUSY_WIDTH_NS = 400;
  localparam int BUSY_CYC = BUSY_WIDTH_NS / CLK_PERIOD_NS;
  localparam int VALID_NS = 640;
  localparam int VALID_CYC = (VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HI_BITS = 8;
  localparam int BUSY_CNT_W = 8;
  localparam logic [BUSY_CNT_W-1:0] BUSY_CNT_RST = 8'h00;

  typedef struct packed {
    logic step_up;
    logic step_dn;
  } atl_step_t;
endpackage

// >>> hw/atl_core.sv
`timescale 1ns/1ps
module atl_core #(
  parameter int RES = 14
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire atl_pkg::atl_step_t step,
  input wire logic hold_n,
  input wire logic en_hi_n,
  input wire logic en_lo_n,
  output logic [RES-1:0] data_out,
  output logic [RES-1:0] data_oe_n,
  output logic busy
);
  logic [1:0] hold_sync_ff;
  logic [1:0] enh_sync_ff;
  logic [1:0] enl_sync_ff;
  logic hold_d_ff;
  logic [RES-1:0] count_ff;
  logic [RES-1:0] nxt_count;
  logic [RES-1:0] latch_ff;
  logic [RES-1:0] nxt_latch;
  logic [atl_pkg::BUSY_CNT_W-1:0] busy_cnt_ff;
  logic [atl_pkg::BUSY_CNT_W-1:0] nxt_busy_cnt;
  logic busy_ff;
  logic nxt_busy;
  logic pend_ff;
  logic nxt_pend;
  logic [RES-1:0] oe_n_ff;
  logic [RES-1:0] nxt_oe_n;
  logic stepped;
  logic release_evt;
  logic [atl_pkg::BUSY_CNT_W-1:0] busy_run_ff;
  logic [atl_pkg::BUSY_CNT_W-1:0] nxt_busy_run;

  // Host pins are synchronised before use; step is same-domain loop logic.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_sync_ff <= 2'h3;
      enh_sync_ff <= 2'h3;
      enl_sync_ff <= 2'h3;
      hold_d_ff <= 1'b1;
    end else begin
      hold_sync_ff <= {hold_sync_ff[0], hold_n};
      enh_sync_ff <= {enh_sync_ff[0], en_hi_n};
      enl_sync_ff <= {enl_sync_ff[0], en_lo_n};
      hold_d_ff <= hold_sync_ff[1];
    end
  end

  assign stepped = step.step_up ^ step.step_dn;
  assign release_evt = hold_sync_ff[1] & ~hold_d_ff;

  always_comb begin
    nxt_count = count_ff;
    if (step.step_up && !step.step_dn) begin
      nxt_count = count_ff + 1'b1;
    end else if (step.step_dn && !step.step_up) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  // The busy pulse runs for its full width; a new step or release during a pulse
  // restarts it so the latch ends on the newest count whenever hold is high.
  always_comb begin
    nxt_busy_cnt = busy_cnt_ff;
    nxt_busy = busy_ff;
    nxt_latch = latch_ff;
    nxt_pend = pend_ff;
    if (stepped || release_evt) begin
      nxt_busy = 1'b1;
      nxt_busy_cnt = atl_pkg::BUSY_CNT_W'(atl_pkg::BUSY_CYC - 1);
      nxt_pend = 1'b1;
    end else if (busy_cnt_ff != atl_pkg::BUSY_CNT_RST) begin
      nxt_busy_cnt = busy_cnt_ff - 1'b1;
    end else if (busy_ff) begin
      nxt_busy = 1'b0;
    end
    // Latch loads the counter on the last busy cycle, only if a refresh is pending and hold is high.
    if (busy_ff && pend_ff && hold_sync_ff[1] && busy_cnt_ff == atl_pkg::BUSY_CNT_RST) begin
      nxt_latch = count_ff;
      if (!(stepped || release_evt)) begin
        nxt_pend = 1'b0;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < RES; i++) begin
      if (i < atl_pkg::HI_BITS) begin
        nxt_oe_n[i] = enh_sync_ff[1];
      end else begin
        nxt_oe_n[i] = enl_sync_ff[1];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= '0;
      latch_ff <= '0;
      busy_cnt_ff <= atl_pkg::BUSY_CNT_RST;
      busy_ff <= 1'b0;
      pend_ff <= 1'b0;
      oe_n_ff <= '1;
    end else begin
      count_ff <= nxt_count;
      latch_ff <= nxt_latch;
      busy_cnt_ff <= nxt_busy_cnt;
      busy_ff <= nxt_busy;
      pend_ff <= nxt_pend;
      oe_n_ff <= nxt_oe_n;
    end
  end

  // Bit index RES-1 is the MSB and goes out on output bit 0.
  genvar g;
  generate
    for (g = 0; g < RES; g++) begin : g_out
      assign data_out[g] = latch_ff[RES-1-g];
      assign data_oe_n[g] = oe_n_ff[g];
    end
  endgenerate
  assign busy = busy_ff;

  // Helper counter of busy-high cycles since the newest step or release.
  always_comb begin
    nxt_busy_run = busy_run_ff;
    if (stepped || release_evt) begin
      nxt_busy_run = atl_pkg::BUSY_CNT_RST;
    end else if (busy_ff) begin
      nxt_busy_run = busy_run_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_run_ff <= atl_pkg::BUSY_CNT_RST;
    end else begin
      busy_run_ff <= nxt_busy_run;
    end
  end

  // Assertions.
  frozen_latch_a: assert property (@(posedge clk) disable iff (!arst_n)
    !hold_sync_ff[1] && !$past(hold_sync_ff[1]) |-> $stable(latch_ff))
    else $error("latch changed during hold");
  count_track_a: assert property (@(posedge clk) disable iff (!arst_n)
    step.step_up && !step.step_dn |=> count_ff == $past(count_ff) + 1'b1)
    else $error("counter did not step up");
  release_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
    release_evt |=> busy_ff)
    else $error("no busy after release");
  oe_hi_a: assert property (@(posedge clk) disable iff (!arst_n)
    oe_n_ff[0] == $past(enh_sync_ff[1]))
    else $error("high enable mismatch");
  oe_lo_a: assert property (@(posedge clk) disable iff (!arst_n)
    oe_n_ff[RES-1] == $past(enl_sync_ff[1]))
    else $error("low enable mismatch");
  busy_width_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(busy_ff) |-> busy_run_ff == atl_pkg::BUSY_CNT_W'(atl_pkg::BUSY_CYC))
    else $error("busy width wrong");
  valid_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(hold_sync_ff[1]) ##1 !hold_sync_ff[1] |-> $stable(latch_ff))
    else $error("data not valid after hold");
  busy_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(busy_ff) && $past(hold_sync_ff[1]) |-> latch_ff == $past(count_ff))
    else $error("latch stale at busy fall");
  step_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
    stepped |=> busy_ff)
    else $error("no busy after step");
  count_down_a: assert property (@(posedge clk) disable iff (!arst_n)
    step.step_dn && !step.step_up |=> count_ff == $past(count_ff) - 1'b1)
    else $error("counter did not step down");
  count_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
    !stepped |=> $stable(count_ff))
    else $error("counter moved without step");
  latch_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
    !$stable(latch_ff) |-> $past(busy_ff))
    else $error("latch changed while not busy");
  latch_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !$stable(latch_ff) |-> $past(hold_sync_ff[1]))
    else $error("latch changed under hold");
  pend_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(busy_ff) && $past(hold_sync_ff[1]) |-> !pend_ff)
    else $error("pending kept after refresh");
  release_pend_a: assert property (@(posedge clk) disable iff (!arst_n)
    release_evt |=> pend_ff)
    else $error("release refresh not pending");
  idle_cnt_a: assert property (@(posedge clk) disable iff (!arst_n)
    !busy_ff |-> busy_cnt_ff == atl_pkg::BUSY_CNT_RST)
    else $error("busy counter runs while idle");
  msb_first_a: assert property (@(posedge clk) disable iff (!arst_n)
    data_out[0] == latch_ff[RES-1])
    else $error("bit order wrong");
  keep_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    stepped |=> pend_ff)
    else $error("step lost");

  step_cov: cover property (@(posedge clk) disable iff (!arst_n) $fell(busy_ff));
  hold_cov: cover property (@(posedge clk) disable iff (!arst_n)
    !hold_sync_ff[1] && stepped);
  rel_cov: cover property (@(posedge clk) disable iff (!arst_n) release_evt);
  read_cov: cover property (@(posedge clk) disable iff (!arst_n)
    !oe_n_ff[0] && !oe_n_ff[RES-1]);
endmodule

// >>> dv/atl_host.sv
`timescale 1ns/1ps
module atl_host #(
  parameter int RES = 14
) (
  input wire logic clk,
  input wire logic [RES-1:0] data_out,
  input wire logic [RES-1:0] data_oe_n,
  input wire logic busy,
  output logic [RES-1:0] bus,
  output logic [RES-1:0] cap
);
  logic [RES-1:0] last_ff = '0;
  logic busy_ff = 1'b0;
  // A floating bit reads as the inverse of its last level.
  assign bus = (data_out & ~data_oe_n) | (~last_ff & data_oe_n);
  always @(posedge clk) begin
    last_ff <= bus;
    busy_ff <= busy;
    if (busy_ff && !busy) begin
      cap <= bus;
    end
  end
endmodule

// >>> dv/angle_tracking_output_latch_tb.sv
`timescale 1ns/1ps
module angle_tracking_output_latch_tb;
  localparam int RES = 14;
  localparam int BW = atl_pkg::BUSY_CYC;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  atl_pkg::atl_step_t step = 2'h0;
  logic hold_n = 1'b1;
  logic en_hi_n = 1'b0;
  logic en_lo_n = 1'b0;
  logic [RES-1:0] data_out, data_oe_n, bus, cap, m;
  logic busy;
  int errors = 0;
  int tests_run = 0;
  int cnt = 0;
  int w;
  atl_core #(.RES(RES)) dut_u (.clk(clk), .arst_n(arst_n), .step(step), .hold_n(hold_n),
    .en_hi_n(en_hi_n), .en_lo_n(en_lo_n), .data_out(data_out), .data_oe_n(data_oe_n),
    .busy(busy));
  atl_host #(.RES(RES)) host_u (.clk(clk), .data_out(data_out), .data_oe_n(data_oe_n),
    .busy(busy), .bus(bus), .cap(cap));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [RES-1:0] rev(input int v);
    for (int i = 0; i < RES; i++) rev[RES-1-i] = v[i];
  endfunction
  task automatic check(input logic [RES-1:0] seen, input logic [RES-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic pulse(input logic [1:0] s);
    @(posedge clk) step <= s;
    @(posedge clk) step <= 2'h0;
  endtask
  task automatic wait_fall();
    w = 0;
    for (int i = 0; i < 200 && (w == 0 || busy === 1'b1); i++) begin
      @(negedge clk);
      if (busy === 1'b1) w++;
    end
    @(negedge clk);
  endtask
  task automatic t_step();
    for (int k = 0; k < 3; k++) begin
      pulse(k < 2 ? 2'h2 : 2'h1);
      cnt = k < 2 ? cnt + 1 : cnt - 1;
      wait_fall();
      check(RES'(w), RES'(BW));
      check(bus, rev(cnt));
      check(cap, rev(cnt));
    end
    pulse(2'h3);
    wait_fall();
    check(RES'(w), '0);
    $display("test step done");
  endtask
  task automatic t_hold();
    @(posedge clk) hold_n <= 1'b0;
    repeat (atl_pkg::VALID_CYC) @(posedge clk);
    pulse(2'h2);
    cnt++;
    wait_fall();
    check(RES'(w), RES'(BW));
    check(bus, rev(cnt - 1));
    @(posedge clk) hold_n <= 1'b1;
    wait_fall();
    check(RES'(w), RES'(BW));
    check(bus, rev(cnt));
    $display("test hold done");
  endtask
  task automatic t_enable();
    for (int k = 0; k < 4; k++) begin
      m = {{(RES-8){k[0]}}, {8{k[1]}}};
      @(posedge clk) {en_hi_n, en_lo_n} <= k[1:0];
      repeat (5) @(negedge clk);
      check(data_oe_n, m);
      check(bus & ~m, rev(cnt) & ~m);
    end
    pulse(2'h2);
    cnt++;
    wait_fall();
    check(RES'(w), RES'(BW));
    @(posedge clk) {en_hi_n, en_lo_n} <= 2'h0;
    repeat (5) @(negedge clk);
    check(bus, rev(cnt));
    $display("test enable done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_step();
    t_hold();
    t_enable();
    end_of_test();
  end
  initial begin
    #100us;
    errors++;
    end_of_test();
  end
endmodule
